// ### include/adc_ctrl_map.svh
// Overview of operation
// R01 - convert start falling while selected and converting starts an internal reset
// R02 - the internal reset ends by itself after a fixed count
// R03 - a finished reset clears every output data latch to zero
// R04 - a finished reset drives busy low
// R05 - after a reset, sampling restarts at the falling edge of busy
// R06 - host toggles read strobe three full cycles after power-on before trusting results
// R07 - power-on reads load trim data; conversions before that are flagged invalid
// R08 - host never ties read strobe permanently low
// R09 - host may hold read strobe active only after the three power-on reads
// R10 - busy rises when a conversion starts and stays high until it ends
// R11 - sampling starts at busy fall with select low, or select fall with busy low
// R12 - data bus driven only while select and read strobe are both low
// R13 - completed read cycles counted, saturating, init done at three
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define ADC_INIT_READS      2'h3
`define ADC_CONV_CYCLES     8'h64
`define ADC_RST_CYCLES      8'h04
`define ADC_DATA_RESET      16'h0000
`endif

// ### include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_RESET = 2'b11
  } state_t;
  typedef struct packed {
    logic        busy;
    logic        sampling;
    logic        init_done;
    logic        result_valid;
  } status_t;
endpackage : adc_ctrl_pkg

// ### verilog/adc_reset_init_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_reset_init_ctrl (
  input  wire logic                  ref_clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  chip_select_n_in,
  input  wire logic                  convert_start_n_in,
  input  wire logic                  read_strobe_n_in,
  input  wire logic [15:0]           result_in,
  output logic [15:0]                data_out,
  output logic                       data_oe_out,
  output var adc_ctrl_pkg::status_t  status_out
);
  adc_ctrl_pkg::state_t state_ff, nxt_state;
  logic [7:0]  cnt_ff, nxt_cnt;
  logic [15:0] data_ff, nxt_data;
  logic        cs_n_ff, cv_n_ff, rd_n_ff;
  logic [1:0]  reads_ff, nxt_reads;
  logic        valid_ff, nxt_valid;
  logic        busy_q_ff;
  logic        cv_fall, rd_rise, busy_fall, cs_fall;
  logic        busy_now, samp_now;

  // edge detect on synchronous pins
  assign cv_fall   = cv_n_ff & ~convert_start_n_in;
  assign rd_rise   = ~rd_n_ff & read_strobe_n_in;
  assign cs_fall   = cs_n_ff & ~chip_select_n_in;
  assign busy_fall = busy_q_ff & (state_ff == adc_ctrl_pkg::ST_IDLE);

  // next state, counters and latches
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_data  = data_ff;
    nxt_valid = valid_ff;
    nxt_reads = reads_ff;
    if (rd_rise && reads_ff != `ADC_INIT_READS) begin
      nxt_reads = reads_ff + 2'h1; // saturating [R13] [R07]
    end
    unique case (state_ff)
      adc_ctrl_pkg::ST_IDLE: begin
        if (cv_fall && !chip_select_n_in) begin
          nxt_state = adc_ctrl_pkg::ST_CONV; // busy rises [R10]
          nxt_cnt   = `ADC_CONV_CYCLES;
        end
      end
      adc_ctrl_pkg::ST_CONV: begin
        if (cv_fall && !chip_select_n_in) begin
          nxt_state = adc_ctrl_pkg::ST_RESET; // abort [R01]
          nxt_cnt   = `ADC_RST_CYCLES;
        end else if (cnt_ff == 8'h01) begin
          nxt_state = adc_ctrl_pkg::ST_IDLE; // conversion ends [R10]
          nxt_data  = result_in;
          // trim not loaded yet: result untrustworthy [R07]
          nxt_valid = (reads_ff == `ADC_INIT_READS);
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      adc_ctrl_pkg::ST_RESET: begin
        if (cnt_ff == 8'h01) begin
          nxt_state = adc_ctrl_pkg::ST_IDLE; // self clear [R02] busy low [R04]
          nxt_data  = `ADC_DATA_RESET; // [R03]
          nxt_valid = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: nxt_state = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  // register stage only
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff  <= adc_ctrl_pkg::ST_IDLE;
      cnt_ff    <= 8'h00;
      data_ff   <= `ADC_DATA_RESET;
      valid_ff  <= 1'b0;
      reads_ff  <= 2'h0;
      cs_n_ff   <= 1'b1;
      cv_n_ff   <= 1'b1;
      rd_n_ff   <= 1'b1;
      busy_q_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      data_ff   <= nxt_data;
      valid_ff  <= nxt_valid;
      reads_ff  <= nxt_reads;
      cs_n_ff   <= chip_select_n_in;
      cv_n_ff   <= convert_start_n_in;
      rd_n_ff   <= read_strobe_n_in;
      busy_q_ff <= (state_ff != adc_ctrl_pkg::ST_IDLE);
    end
  end

  // bus driver: enable is combinational, data from flops
  assign data_out    = data_ff;
  assign data_oe_out = ~chip_select_n_in & ~read_strobe_n_in; // [R12]

  // sampling pulse: busy fall with select low, or select fall idle [R05] [R11]
  assign busy_now = (state_ff != adc_ctrl_pkg::ST_IDLE);
  assign samp_now = (busy_fall & ~chip_select_n_in) |
                    (cs_fall & ~busy_q_ff & (state_ff == adc_ctrl_pkg::ST_IDLE));
  // one assign for the whole word keeps the status port a single driver
  assign status_out = '{busy:         busy_now,
                        sampling:     samp_now,
                        init_done:    (reads_ff == `ADC_INIT_READS),
                        result_valid: valid_ff};

  // a second start while converting must abort
  property p_abort;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (state_ff == adc_ctrl_pkg::ST_CONV && cv_fall && !chip_select_n_in) |=> state_ff == adc_ctrl_pkg::ST_RESET;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missed"); // [R01]

  // reset length is fixed, host never has to end it
  property p_selfclear;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      $rose(state_ff == adc_ctrl_pkg::ST_RESET) |-> ##[1:4] state_ff == adc_ctrl_pkg::ST_IDLE;
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("reset stuck"); // [R02]

  // output latch zero on leaving reset
  property p_zero;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      ($past(state_ff) == adc_ctrl_pkg::ST_RESET && state_ff == adc_ctrl_pkg::ST_IDLE) |-> data_ff == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("latch not cleared"); // [R03]

  // busy drops with the end of reset
  property p_busylow;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      ($past(state_ff) == adc_ctrl_pkg::ST_RESET && state_ff == adc_ctrl_pkg::ST_IDLE) |-> !status_out.busy;
  endproperty
  a_busylow: assert property (p_busylow) else $error("busy high after reset"); // [R04]

  // acquisition restarts at busy fall
  property p_samp;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (busy_fall && !chip_select_n_in) |-> status_out.sampling;
  endproperty
  a_samp: assert property (p_samp) else $error("no sampling at busy fall"); // [R05]

  // busy may not glitch low just after it rises
  property p_busyhold;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      $rose(status_out.busy) |-> status_out.busy [*4];
  endproperty
  a_busyhold: assert property (p_busyhold) else $error("busy dropped early"); // [R10]

  // bus enable follows select and strobe only
  property p_oe;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      data_oe_out == (!chip_select_n_in && !read_strobe_n_in);
  endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong"); // [R12]

  // counter saturates, so init never reverts
  property p_sat;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      status_out.init_done |=> status_out.init_done;
  endproperty
  a_sat: assert property (p_sat) else $error("init flag lost"); // [R13]

  // no trusted result before the trim load
  property p_inval;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      status_out.result_valid |-> status_out.init_done;
  endproperty
  a_inval: assert property (p_inval) else $error("valid before trim"); // [R07]

  // start with select high is ignored while idle
  property p_refuse;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (state_ff == adc_ctrl_pkg::ST_IDLE && cv_fall && chip_select_n_in) |=> state_ff == adc_ctrl_pkg::ST_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken without select"); // [R01]

  // reset runs its full count, starts cannot cut it short
  property p_rsthold;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (state_ff == adc_ctrl_pkg::ST_RESET && cnt_ff != 8'h01) |=> state_ff == adc_ctrl_pkg::ST_RESET;
  endproperty
  a_rsthold: assert property (p_rsthold) else $error("reset left early"); // [R02]

  // a clean end of conversion stores the result and drops busy
  property p_convend;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (state_ff == adc_ctrl_pkg::ST_CONV && cnt_ff == 8'h01 && !(cv_fall && !chip_select_n_in))
      |=> (!status_out.busy && data_ff == $past(result_in));
  endproperty
  a_convend: assert property (p_convend) else $error("result not stored at end"); // [R10]

  // each completed read advances the count until saturation
  property p_reads;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (rd_rise && reads_ff != `ADC_INIT_READS) |=> reads_ff == $past(reads_ff) + 2'h1;
  endproperty
  a_reads: assert property (p_reads) else $error("read not counted"); // [R13]

  // an aborted result must never look valid
  property p_rstvalid;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      ($past(state_ff) == adc_ctrl_pkg::ST_RESET && state_ff == adc_ctrl_pkg::ST_IDLE) |-> !status_out.result_valid;
  endproperty
  a_rstvalid: assert property (p_rstvalid) else $error("valid after reset"); // [R03]

  // select fall while idle opens acquisition
  property p_sampcs;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (cs_fall && !busy_q_ff && state_ff == adc_ctrl_pkg::ST_IDLE) |-> status_out.sampling;
  endproperty
  a_sampcs: assert property (p_sampcs) else $error("no sampling at select fall"); // [R11]

  // never sample while a conversion or reset runs
  property p_sampidle;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      status_out.sampling |-> state_ff == adc_ctrl_pkg::ST_IDLE;
  endproperty
  a_sampidle: assert property (p_sampidle) else $error("sampling while busy"); // [R05]
endmodule : adc_reset_init_ctrl
`default_nettype wire

// ### verification/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic ref_clk_in,
  output logic      cs_n_out,
  output logic      cv_n_out,
  output logic      rd_n_out
);
  // strobes move 1 ns after the edge and stay put for a full cycle
  task automatic set_bus(input logic cs, input logic rd);
    @(posedge ref_clk_in) #1 cs_n_out = cs;
    rd_n_out = rd;
  endtask : set_bus
  // start held low one cycle; select stays where it was put
  task automatic start(input logic cs);
    @(posedge ref_clk_in) #1 cs_n_out = cs;
    cv_n_out = 1'b0;
    @(posedge ref_clk_in) #1 cv_n_out = 1'b1;
  endtask : start
  // every read returns high, so the strobe is never parked low
  task automatic read_cycle();
    set_bus(cs_n_out, 1'b0);
    set_bus(cs_n_out, 1'b1);
  endtask : read_cycle
  initial begin
    cs_n_out = 1'b1;
    cv_n_out = 1'b1;
    rd_n_out = 1'b1;
  end
endmodule : host_model
`default_nettype wire

// ### verification/sar_adc_reset_and_init_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sar_adc_reset_and_init_control_bench;
  logic                  clk, arst_n, cs_n, cv_n, rd_n, oe, saw;
  logic [15:0]           res, data, r;
  adc_ctrl_pkg::status_t st;
  logic [15:0]           exp_q[$];
  int                    failures = 0, samples_checked = 0, seed = 93, cycles = 0, reads = 0;
  host_model u_host_model (.ref_clk_in(clk), .cs_n_out(cs_n), .cv_n_out(cv_n), .rd_n_out(rd_n));
  adc_reset_init_ctrl u_adc_reset_init_ctrl (.ref_clk_in(clk), .arst_n_in(arst_n), .chip_select_n_in(cs_n),
    .convert_start_n_in(cv_n), .read_strobe_n_in(rd_n), .result_in(res), .data_out(data),
    .data_oe_out(oe), .status_out(st));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard; the sampling pulse lasts one cycle, so latch it
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (st.sampling === 1'b1) saw <= 1'b1;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic v, input int lim);
    for (int n = 0; n < lim && st.busy !== v; n++) @(posedge clk) #2;
  endtask : wait_busy
  // one full conversion; validity follows the read count
  task automatic convert();
    r = 16'($random(seed));
    res = r;
    exp_q.push_back(r);
    u_host_model.start(1'b0);
    wait_busy(1'b1, 3);
    check("busy rise", 16'(st.busy), 16'h0001);
    saw = 1'b0;
    wait_busy(1'b0, 110);
    #20 check("data", data, exp_q.pop_front());
    check("valid", 16'(st.result_valid), 16'(reads >= 3));
    check("sample", 16'(saw), 16'h0001);
  endtask : convert
  initial begin
    arst_n = 1'b0;
    res = 16'h0000;
    saw = 1'b0;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_host_model.set_bus(i[0], i[1]);
      #2 check("oe", 16'(oe), 16'(i == 0));
    end
    reads = 1;
    u_host_model.start(1'b1);
    repeat (3) @(posedge clk);
    check("busy refused", 16'(st.busy), 16'h0000);
    convert();
    for (int k = 0; k < 2; k++) begin
      u_host_model.read_cycle();
      reads++;
      @(posedge clk) #2 check("init", 16'(st.init_done), 16'(reads >= 3));
    end
    convert();
    // select fall with busy low opens acquisition
    u_host_model.set_bus(1'b1, 1'b1);
    saw = 1'b0;
    u_host_model.set_bus(1'b0, 1'b1);
    @(posedge clk) #2 check("select sample", 16'(saw), 16'h0001);
    u_host_model.start(1'b0);
    repeat (10) @(posedge clk);
    saw = 1'b0;
    u_host_model.start(1'b0);
    wait_busy(1'b0, 10);
    #20 check("abort busy", 16'(st.busy), 16'h0000);
    exp_q.push_back(16'h0000);
    check("abort data", data, exp_q.pop_front());
    check("abort sample", 16'(saw), 16'h0001);
    repeat (110) @(posedge clk);
    check("no late end", 16'(st.busy), 16'h0000);
    check("data stays", data, 16'h0000);
    results();
  end
endmodule : sar_adc_reset_and_init_control_bench
`default_nettype wire
